// File: hw/tmc_pkg.sv
// Constants and carrier types for the four-channel 8-bit timer control/status block.
// Assumes the counters, constant registers and interrupt enables live outside this block.
package tmc_pkg;

  localparam int          NUM_CH       = 4;
  localparam int          CNT_W        = 8;
  localparam int          CSR_W        = 8;
  localparam int          FLAG_W       = 3;

  // Bit positions inside each control/status register.
  localparam int          BIT_FLAG_B   = 7;
  localparam int          BIT_FLAG_A   = 6;
  localparam int          BIT_WRAP     = 5;
  localparam int          BIT_MODE     = 4;
  localparam int          BIT_BACT_HI  = 3;
  localparam int          BIT_BACT_LO  = 2;
  localparam int          BIT_AACT_HI  = 1;
  localparam int          BIT_AACT_LO  = 0;

  // Index of each flag inside the packed flag vector.
  localparam int          FI_B         = 2;
  localparam int          FI_A         = 1;
  localparam int          FI_WRAP      = 0;

  localparam logic [7:0]  CSR_RESET    = 8'h00;
  localparam logic [4:0]  CTRL_RESET   = 5'h00;
  localparam logic [2:0]  FLAG_RESET   = 3'h0;
  localparam logic [7:0]  CNT_MAX      = 8'hff;

  // Output actions; the encoding is also the priority order.
  localparam logic [1:0]  ACT_NONE     = 2'h0;
  localparam logic [1:0]  ACT_LOW      = 2'h1;
  localparam logic [1:0]  ACT_HIGH     = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h3;

  // Capture edge selections.
  localparam logic [1:0]  EDGE_RISE    = 2'h0;
  localparam logic [1:0]  EDGE_FALL    = 2'h1;
  localparam logic [1:0]  EDGE_BOTH    = 2'h2;

  localparam logic [1:0]  CH_CONV      = 2'h0;

  typedef struct packed {
    logic             tick;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] const_a;
    logic [CNT_W-1:0] const_b;
  } tmc_chan_in_t;

  typedef struct packed {
    logic irq_en_b;
    logic irq_en_a;
    logic irq_en_wrap;
  } tmc_irq_en_t;

  typedef struct packed {
    logic match_b_irq;
    logic match_a_irq;
    logic wrap_irq;
  } tmc_irq_t;

endpackage

// File: hw/tmc_ctrl_status.sv
// Control/status registers, flags, pin actions and converter trigger for a four-channel 8-bit timer.
// Assumes counters tick outside with a one-cycle tick pulse and all inputs synchronous to i_ref_clk.
// Function
// - Writing one to any of the three status flags leaves it unchanged.
// - All control/status registers return to zero on reset and standby.
// - B flag sets on counter equals B compare, or on capture.
// - A flag sets when counter equals the A constant.
// - Wrap flag sets when the counter wraps from all ones to zero.
// - Odd-channel capture mode stops the paired even channel's B match setting its flag.
// - Bit 4 of channels 1 and 3 selects compare or capture for B.
// - Converter starts follow trigger enable and external trigger enable.
// - Channel 2 bit 4 stores and returns whatever software writes.
// - Channel 1 capture mode: channel 0 B match drives no output, no irq.
// - Channel 1 capture mode: its pin is input only; A match still works.
// - Channel 1 capture mode: capture sets its B flag; channel 0 A normal.
// - Channels 2 and 3 pair the same way under channel 3 capture mode.
// - Bits 3:2 select B output action or capture edge per pair mode.
// - B action: none, low, high, toggle; edge: rising, falling, both.
// - Bits 1:0 select A action; bits 3:0 all zero disables the output.
// - Simultaneous A and B matches follow the higher-priority action.
`timescale 1ns/1ps
module tmc_ctrl_status
  import tmc_pkg::*;
#(
  parameter int NUM_CHAN = 4
)
(
  // Clock and reset.
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_sys_rst,
  input  wire logic                              i_standby,
  // Register port.
  input  wire logic [1:0]                        i_csr_sel,
  input  wire logic                              i_csr_rd,
  input  wire logic                              i_csr_wr,
  input  wire logic [CSR_W-1:0]                  i_csr_wdata,
  output      logic [CSR_W-1:0]                  o_csr_rdata,
  // Channel state and interrupt enables.
  input  wire tmc_pkg::tmc_chan_in_t [NUM_CH-1:0] i_chan,
  input  wire tmc_pkg::tmc_irq_en_t  [NUM_CH-1:0] i_irq_en,
  output      tmc_pkg::tmc_irq_t     [NUM_CH-1:0] o_irq,
  // Timer pins and capture strobe.
  input  wire logic [NUM_CH-1:0]                 i_timer_inout_pin,
  output      logic [NUM_CH-1:0]                 o_timer_out_pin,
  output      logic [NUM_CH-1:0]                 o_timer_out_oe,
  output      logic [NUM_CH-1:0]                 o_capture_load,
  // Converter trigger.
  input  wire logic                              i_converter_ext_trigger_enable,
  input  wire logic                              i_converter_trigger_pin,
  output      logic                              o_converter_start
);
  import tmc_pkg::*;

  if (NUM_CHAN != NUM_CH)
  begin : g_bad_num
    $error("tmc_ctrl_status serves exactly four paired channels");
  end

  function automatic logic [1:0] act_max(input logic [1:0] a, input logic [1:0] b);
    act_max = (a > b) ? a : b;
  endfunction

  function automatic logic act_apply(input logic cur, input logic [1:0] act);
    unique case (act)
      ACT_LOW:    act_apply = 1'b0;
      ACT_HIGH:   act_apply = 1'b1;
      ACT_TOGGLE: act_apply = ~cur;
      default:    act_apply = cur;
    endcase
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    unique case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  logic [NUM_CH-1:0][FLAG_W-1:0] flag_ff;
  logic [NUM_CH-1:0][FLAG_W-1:0] armed_ff;
  logic [NUM_CH-1:0][4:0]        ctrl_ff;
  logic [NUM_CH-1:0]             pin_d_ff;
  logic [NUM_CH-1:0]             out_ff;
  logic [CSR_W-1:0]              rdata_ff;
  logic                          conv_ff;
  logic [NUM_CH-1:0]             hit_a;
  logic [NUM_CH-1:0]             hit_b;
  logic [NUM_CH-1:0]             hit_wrap;
  logic [NUM_CH-1:0]             cap_mode;
  logic [NUM_CH-1:0]             cap_evt;
  logic [NUM_CH-1:0]             set_b;
  logic [NUM_CH-1:0]             out_b;
  logic [NUM_CH-1:0][FLAG_W-1:0] nxt_flag;
  logic [NUM_CH-1:0]             nxt_out;

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chan
    localparam bit IS_ODD = (g % 2) == 1;
    logic [1:0] act_a;
    logic [1:0] act_b;

    assign hit_a[g]    = i_chan[g].tick && (i_chan[g].count == i_chan[g].const_a);
    assign hit_b[g]    = i_chan[g].tick && (i_chan[g].count == i_chan[g].const_b);
    assign hit_wrap[g] = i_chan[g].tick && (i_chan[g].count == CNT_MAX);
    // The pair's mode bit lives in the odd channel of the pair.
    assign cap_mode[g] = ctrl_ff[g | 1][BIT_MODE];

    if (IS_ODD)
    begin : g_odd
      assign cap_evt[g] = cap_mode[g]
                          && edge_hit(ctrl_ff[g][BIT_BACT_HI:BIT_BACT_LO],
                                      i_timer_inout_pin[g] & ~pin_d_ff[g],
                                      ~i_timer_inout_pin[g] & pin_d_ff[g]);
      assign set_b[g]   = cap_mode[g] ? cap_evt[g] : hit_b[g];
    end
    else
    begin : g_even
      assign cap_evt[g] = 1'b0;
      assign set_b[g]   = hit_b[g] && !cap_mode[g];
    end

    // No B output action while the pair captures, on either channel.
    assign out_b[g] = hit_b[g] && !cap_mode[g];
    assign act_a    = hit_a[g] ? ctrl_ff[g][BIT_AACT_HI:BIT_AACT_LO] : ACT_NONE;
    assign act_b    = out_b[g] ? ctrl_ff[g][BIT_BACT_HI:BIT_BACT_LO] : ACT_NONE;
    assign nxt_out[g] = act_apply(out_ff[g], act_max(act_a, act_b));

    // Set wins over a clear that lands in the same cycle.
    for (genvar f = 0; f < FLAG_W; f++)
    begin : g_flag
      logic set_evt;
      logic clr_evt;
      if (f == FI_B)
      begin : g_sb
        assign set_evt = set_b[g];
      end
      else if (f == FI_A)
      begin : g_sa
        assign set_evt = hit_a[g];
      end
      else
      begin : g_sw
        assign set_evt = hit_wrap[g];
      end
      // Only a zero written after reading the flag set clears it; a one is ignored.
      assign clr_evt = i_csr_wr && (i_csr_sel == 2'(g)) && !i_csr_wdata[BIT_WRAP + f]
                       && armed_ff[g][f];
      assign nxt_flag[g][f] = set_evt | (flag_ff[g][f] & ~clr_evt);
    end

    // Output enable drops when all action bits are zero or the pin is a capture input.
    assign o_timer_out_oe[g] = (ctrl_ff[g][BIT_BACT_HI:BIT_AACT_LO] != '0) && !(IS_ODD && cap_mode[g]);
    assign o_capture_load[g] = cap_evt[g];
    assign o_irq[g].match_b_irq = flag_ff[g][FI_B] && i_irq_en[g].irq_en_b;
    assign o_irq[g].match_a_irq = flag_ff[g][FI_A] && i_irq_en[g].irq_en_a;
    assign o_irq[g].wrap_irq    = flag_ff[g][FI_WRAP] && i_irq_en[g].irq_en_wrap;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      flag_ff <= '0;
    else if (i_standby)
      flag_ff <= '0;
    else
      flag_ff <= nxt_flag;
  end

  // A read of a set flag arms its clear; any write to that register disarms it.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      armed_ff <= '0;
    else if (i_standby)
      armed_ff <= '0;
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (i_csr_wr && (i_csr_sel == 2'(c)))
          armed_ff[c] <= FLAG_RESET;
        else if (i_csr_rd && (i_csr_sel == 2'(c)))
          armed_ff[c] <= armed_ff[c] | flag_ff[c];
      end
    end
  end

  // Bit 4 is stored on every channel; on channel 2 it has no function but reads back.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      ctrl_ff <= '0;
    else if (i_standby)
      ctrl_ff <= '0;
    else if (i_csr_wr)
      ctrl_ff[i_csr_sel] <= i_csr_wdata[BIT_MODE:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rdata_ff <= CSR_RESET;
    else if (i_csr_rd)
      rdata_ff <= {flag_ff[i_csr_sel], ctrl_ff[i_csr_sel]};
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pin_d_ff <= '0;
    else
      pin_d_ff <= i_timer_inout_pin;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      out_ff <= '0;
    else if (i_standby)
      out_ff <= '0;
    else
      out_ff <= nxt_out;
  end

  // Registered so the request follows the A match pulse or the trigger pin level one cycle later.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      conv_ff <= 1'b0;
    else if (!i_converter_ext_trigger_enable)
      conv_ff <= 1'b0;
    else if (ctrl_ff[CH_CONV][BIT_MODE])
      conv_ff <= hit_a[CH_CONV];
    else
      conv_ff <= i_converter_trigger_pin;
  end

  assign o_csr_rdata       = rdata_ff;
  assign o_timer_out_pin   = out_ff;
  assign o_converter_start = conv_ff;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_w1_keeps;
    (i_csr_wr && i_csr_sel == 2'h0 && i_csr_wdata[BIT_FLAG_A] && flag_ff[0][FI_A] && !i_standby)
      |=> flag_ff[0][FI_A];
  endproperty
  a_w1_keeps: assert property (p_w1_keeps) else $error("Flag A lost on a one write.");

  property p_unarmed_keeps;
    (i_csr_wr && i_csr_sel == 2'h2 && !i_csr_wdata[BIT_WRAP] && !armed_ff[2][FI_WRAP]
      && flag_ff[2][FI_WRAP] && !i_standby) |=> flag_ff[2][FI_WRAP];
  endproperty
  a_unarmed_keeps: assert property (p_unarmed_keeps) else $error("Wrap flag cleared without a read.");

  property p_standby_zero;
    i_standby |=> (flag_ff == '0) && (ctrl_ff == '0);
  endproperty
  a_standby_zero: assert property (p_standby_zero) else $error("Registers not zero after standby.");

  property p_cmp_b_sets;
    (hit_b[1] && !ctrl_ff[1][BIT_MODE] && !i_standby) |=> flag_ff[1][FI_B];
  endproperty
  a_cmp_b_sets: assert property (p_cmp_b_sets) else $error("B compare did not set the flag.");

  property p_a_sets;
    (hit_a[2] && !i_standby) |=> flag_ff[2][FI_A];
  endproperty
  a_a_sets: assert property (p_a_sets) else $error("A match did not set the flag.");

  property p_wrap_sets;
    (i_chan[3].tick && i_chan[3].count == CNT_MAX && !i_standby) |=> flag_ff[3][FI_WRAP];
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("Wrap did not set the flag.");

  property p_pair_block;
    (hit_b[0] && ctrl_ff[1][BIT_MODE] && !flag_ff[0][FI_B]) |=> !flag_ff[0][FI_B];
  endproperty
  a_pair_block: assert property (p_pair_block) else $error("Paired B match set the flag.");

  property p_conv_blocked;
    !i_converter_ext_trigger_enable |=> !o_converter_start;
  endproperty
  a_conv_blocked: assert property (p_conv_blocked) else $error("Converter start while disabled.");

  property p_conv_pin;
    (i_converter_ext_trigger_enable && !ctrl_ff[CH_CONV][BIT_MODE] && !i_converter_trigger_pin)
      |=> !o_converter_start;
  endproperty
  a_conv_pin: assert property (p_conv_pin) else $error("Converter start without the pin.");

  property p_cap_input;
    ctrl_ff[3][BIT_MODE] |-> !o_timer_out_oe[3];
  endproperty
  a_cap_input: assert property (p_cap_input) else $error("Capture pin driven.");

  property p_cap_sets;
    (o_capture_load[1] && !i_standby) |=> flag_ff[1][FI_B];
  endproperty
  a_cap_sets: assert property (p_cap_sets) else $error("Capture did not set the flag.");

  property p_toggle;
    (hit_a[0] && ctrl_ff[0][BIT_AACT_HI:BIT_AACT_LO] == ACT_TOGGLE && !i_standby)
      |=> (out_ff[0] != $past(out_ff[0]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle on A match missing.");

  property p_irq_follows;
    (flag_ff[2][FI_B] && i_irq_en[2].irq_en_b) |-> o_irq[2].match_b_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("B irq missing while flag set.");

endmodule

// File: bench/tmc_ctrl_status_test.sv
// Self-checking bench for the timer control/status block: registers, flags, pins, capture, converter start.
// Assumes the block's register port, channel inputs and pins are driven directly, one clock, no partner.
`timescale 1ns/1ps
module tmc_ctrl_status_test;
  import tmc_pkg::*;
  logic                      clk, rst, stby, rd, wr, ext_en, trig_pin, conv;
  logic [1:0]                sel;
  logic [7:0]                wd, rdat, v, cnt, ca, cb;
  logic [2:0]                f;
  logic [31:0]               r;
  tmc_chan_in_t [NUM_CH-1:0] chan;
  tmc_irq_en_t  [NUM_CH-1:0] irq_en;
  tmc_irq_t     [NUM_CH-1:0] irq;
  logic [NUM_CH-1:0]         pin_in, pin_out, oe, cap;
  logic                      cur;
  int                        miscompares, n_compared, seed;

  tmc_ctrl_status #(.NUM_CHAN(4)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_standby(stby), .i_csr_sel(sel), .i_csr_rd(rd),
    .i_csr_wr(wr), .i_csr_wdata(wd), .o_csr_rdata(rdat), .i_chan(chan), .i_irq_en(irq_en),
    .o_irq(irq), .i_timer_inout_pin(pin_in), .o_timer_out_pin(pin_out), .o_timer_out_oe(oe),
    .o_capture_load(cap), .i_converter_ext_trigger_enable(ext_en),
    .i_converter_trigger_pin(trig_pin), .o_converter_start(conv));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // An idle cycle after each access keeps a strobe from falling and rising in one time step.
  task automatic rd_reg(input logic [1:0] s, output logic [7:0] d);
    sel = s;
    rd = 1'b1;
    cyc();
    rd = 1'b0;
    d = rdat;
    cyc();
  endtask

  task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
    sel = s;
    wd = d;
    wr = 1'b1;
    cyc();
    wr = 1'b0;
    cyc();
  endtask

  // One counter increment on one channel; flags land at the edge that samples it.
  task automatic ev(input logic [1:0] c, input logic [7:0] n, input logic [7:0] a, input logic [7:0] b);
    chan[c] = '{tick: 1'b1, count: n, const_a: a, const_b: b};
    cyc();
    chan[c].tick = 1'b0;
  endtask

  function automatic logic [2:0] exp_flags(input logic [7:0] n, input logic [7:0] a, input logic [7:0] b);
    return {n == b, n == a, n == CNT_MAX};
  endfunction

  function automatic logic apply(input logic c, input logic [1:0] act);
    case (act)
      ACT_LOW:    return 1'b0;
      ACT_HIGH:   return 1'b1;
      ACT_TOGGLE: return ~c;
      default:    return c;
    endcase
  endfunction

  function automatic logic exp_cap(input int e, input logic rise);
    return (e == 2) || (rise ? (e == 0) : (e == 1));
  endfunction

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #60000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'head380ac;
    {rst, stby, rd, wr, sel, wd, ext_en, trig_pin, pin_in} = '0;
    rst = 1'b1;
    chan = '0;
    irq_en = '1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(2'(i), v);
      chk(v, CSR_RESET);
    end
    $display("end of reset test");
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      wr_reg(2'(i), v | 8'he0);
      rd_reg(2'(i), ca);
      chk(ca, {3'h0, v[4:0]});
      wr_reg(2'(i), 8'h00);
    end
    $display("end of register test");
    for (int k = 0; k < 24; k++)
    begin
      r = $random(seed);
      ca = r[15:8];
      cnt = r[2] ? ca : r[23:16];
      cb = r[3] ? cnt : r[31:24];
      if (r[4])
        cnt = CNT_MAX;
      irq_en[r[1:0]] = r[7:5];
      ev(r[1:0], cnt, ca, cb);
      f = exp_flags(cnt, ca, cb);
      chk({5'h0, irq[r[1:0]]}, {5'h0, f & r[7:5]});
      rd_reg(r[1:0], v);
      chk(v, {f, 5'h00});
      wr_reg(r[1:0], 8'h00);
      rd_reg(r[1:0], v);
      chk(v, 8'h00);
    end
    irq_en = '1;
    ev(2'd2, 8'hff, 8'hff, 8'hff);
    wr_reg(2'd2, 8'h00);
    rd_reg(2'd2, v);
    chk(v, 8'he0);
    wr_reg(2'd2, 8'he0);
    rd_reg(2'd2, v);
    chk(v, 8'he0);
    wr_reg(2'd2, 8'h00);
    rd_reg(2'd2, v);
    chk(v, 8'h00);
    $display("end of flag test");
    wr_reg(2'd1, 8'h1c);
    wr_reg(2'd0, 8'h0c);
    ev(2'd0, 8'h05, 8'h09, 8'h05);
    chk({6'h0, irq[0].match_b_irq, pin_out[0]}, 8'h00);
    rd_reg(2'd0, v);
    chk(v, 8'h0c);
    chk({7'h0, oe[1]}, 8'h00);
    ev(2'd1, 8'h22, 8'h22, 8'h00);
    rd_reg(2'd1, v);
    chk(v, 8'h5c);
    for (int e = 0; e < 4; e++)
    begin
      wr_reg(2'd1, 8'h10 | 8'(e << 2));
      pin_in[1] = 1'b1;
      #1;
      chk({7'h0, cap[1]}, {7'h0, exp_cap(e, 1'b1)});
      cyc();
      pin_in[1] = 1'b0;
      #1;
      chk({7'h0, cap[1]}, {7'h0, exp_cap(e, 1'b0)});
      cyc();
    end
    // The first write of the loop cleared the A flag that the earlier read had armed.
    rd_reg(2'd1, v);
    chk(v, 8'h9c);
    wr_reg(2'd1, 8'h00);
    $display("end of capture test");
    cur = pin_out[0];
    for (int ab = 0; ab < 32; ab++)
    begin
      wr_reg(2'd0, 8'(ab[3:0]));
      chk({7'h0, oe[0]}, {7'h0, ab[3:0] != 4'h0});
      ev(2'd0, 8'h33, 8'h33, ab[4] ? 8'h33 : 8'h34);
      v[1:0] = ab[4] ? ab[3:2] : ACT_NONE;
      cur = apply(cur, (v[1:0] > ab[1:0]) ? v[1:0] : ab[1:0]);
      chk({7'h0, pin_out[0]}, {7'h0, cur});
    end
    $display("end of output test");
    for (int m = 0; m < 16; m++)
    begin
      wr_reg(2'd0, {3'h0, m[0], 4'h0});
      ext_en = m[1];
      trig_pin = m[2];
      ev(2'd0, 8'h40, m[3] ? 8'h40 : 8'h41, 8'h00);
      chk({7'h0, conv}, {7'h0, m[1] & (m[0] ? m[3] : m[2])});
      trig_pin = 1'b0;
    end
    $display("end of converter test");
    wr_reg(2'd3, 8'h18);
    pin_in[3] = 1'b1;
    ev(2'd2, 8'h05, 8'h09, 8'h05);
    chk({5'h0, oe[3], irq[3].match_b_irq, irq[2].match_b_irq}, 8'h02);
    pin_in[3] = 1'b0;
    wr_reg(2'd3, 8'h1f);
    stby = 1'b1;
    cyc();
    stby = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(2'(i), v);
      chk(v, CSR_RESET);
    end
    $display("end of standby test");
    report_and_stop();
  end
endmodule
